// [src/spi_pkg.sv]
// Purpose: constants and state carriers for the step pulse position input block
// Assumes: 25 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes:   offsets are byte addresses of aligned 32-bit words
package spi_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_NUM     = 8'h04;
    localparam logic [7:0] REG_DEN     = 8'h08;
    localparam logic [7:0] REG_PERIOD  = 8'h0C;
    localparam logic [7:0] REG_TIMEIDX = 8'h10;
    localparam logic [7:0] REG_STATUS  = 8'h14;
    localparam logic [7:0] REG_IRQSTAT = 8'h18;
    localparam logic [7:0] REG_IRQMASK = 8'h1C;
    localparam logic [7:0] REG_DEMAND  = 8'h20;
    localparam logic [7:0] REG_ACTUAL  = 8'h24;
    localparam logic [7:0] REG_FEWIN   = 8'h28;
    localparam logic [7:0] REG_FETIME  = 8'h2C;
    localparam logic [7:0] REG_POLES   = 8'h30;

    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int         CTRL_SUBMODE_BIT = 8;
    localparam int         CTRL_CLOSED_BIT  = 9;
    localparam int         STATUS_FE_BIT    = 13;
    localparam logic [7:0] MODE_PULSE       = 8'hFF;
    localparam logic [7:0] MODE_RESET       = 8'h00;
    localparam logic [7:0] TIME_INDEX_MS    = 8'hFD;
    localparam logic [15:0] NUM_RESET       = 16'h0080;
    localparam logic [15:0] DEN_RESET       = 16'h0001;
    localparam logic [15:0] PERIOD_RESET    = 16'h0001;
    localparam logic [15:0] POLES_RESET     = 16'h0032;
    localparam logic [2:0]  FULL_STEPS_PER_POLE_SHIFT = 3'h2;
    localparam int         IRQ_CYCLE = 0;
    localparam int         IRQ_FE    = 1;
    localparam int         IRQ_LOST  = 2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {SUB_CLKDIR, SUB_CWCCW} spi_sub_t;

    typedef struct packed {
        logic [7:0]  mode;
        spi_sub_t    submode;
        logic        closed;
        logic [15:0] num;
        logic [15:0] den;
        logic [15:0] period;
        logic [15:0] poles;
        logic [31:0] actual;
        logic [31:0] feWin;
        logic [15:0] feTime;
        logic [2:0]  irqStat;
        logic [2:0]  irqMask;
    } spi_regs_t;

    typedef struct packed {
        logic        awHave;
        logic [7:0]  awAddr;
        logic        wHave;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        awRdy;
        logic        wRdy;
        logic        bValid;
        logic [1:0]  bResp;
        logic        arRdy;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
    } spi_axi_t;

    typedef struct packed {
        spi_regs_t   regs;
        spi_axi_t    axi;
        logic [1:0]  s1;
        logic [1:0]  s2;
        logic [1:0]  s3;
        logic [15:0] msCnt;
        logic [15:0] perCnt;
        logic [15:0] accum;
        logic [31:0] rem;
        logic [31:0] demand;
        logic [15:0] feCnt;
        logic        fe;
        logic        irq;
    } spi_state_t;

endpackage

// [src/step_pulse_input.sv]
// Purpose: step/direction pulse input, per-cycle buffering, scaling to demand position
// Assumes: pulse pins asynchronous to clock; actual position written by software
// Notes:   direction level high means positive count; register access over AXI4-Lite
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
module spi_step_pulse_input
    import spi_pkg::*;
#(
    parameter int MsCycles = MS_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        pulseClk,
    input  wire logic        pulseDir,
    output logic [31:0]      demandPos,
    output logic             followErr,
    output logic             irq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rstPipe;
    logic       rstSync;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync = rstPipe[1];

    // ************************************************************
    // state
    // ************************************************************
    spi_state_t q;
    spi_state_t d;

    logic               riseA;
    logic               riseB;
    logic               active;
    logic               msTick;
    logic               cycTick;
    logic signed [15:0] delta;
    logic signed [47:0] prod;
    logic signed [47:0] sum;
    logic signed [47:0] step;
    logic signed [47:0] divisor;
    logic signed [32:0] err;
    logic [32:0]        errAbs;
    logic               writeGo;
    logic [31:0]        wMask;
    logic [31:0]        wVal;
    logic               wHit;
    logic [31:0]        rVal;
    logic               rHit;
    logic [2:0]         irqSet;

    function automatic logic [31:0] regRead(input spi_state_t s, input logic [7:0] a, output logic hit);
        logic [31:0] v;
        v   = 32'h0;
        hit = 1'b1;
        unique case (a)
            REG_CTRL:    v = {22'h0, s.regs.closed, (s.regs.submode == SUB_CWCCW), s.regs.mode};
            REG_NUM:     v = {16'h0, s.regs.num};
            REG_DEN:     v = {16'h0, s.regs.den};
            REG_PERIOD:  v = {16'h0, s.regs.period};
            REG_TIMEIDX: v = {{24{TIME_INDEX_MS[7]}}, TIME_INDEX_MS};
            REG_STATUS:  v = 32'(s.fe) << STATUS_FE_BIT;
            REG_IRQSTAT: v = {29'h0, s.regs.irqStat};
            REG_IRQMASK: v = {29'h0, s.regs.irqMask};
            REG_DEMAND:  v = s.demand;
            REG_ACTUAL:  v = s.regs.actual;
            REG_FEWIN:   v = s.regs.feWin;
            REG_FETIME:  v = {16'h0, s.regs.feTime};
            // full steps per revolution read back beside the pole pair count
            REG_POLES:   v = {s.regs.poles << FULL_STEPS_PER_POLE_SHIFT, s.regs.poles};
            default:     hit = 1'b0;
        endcase
        return v;
    endfunction

    always_comb begin
        d = q;

        // ********************************************************
        // pulse inputs: two flops, then a third for edge finding
        // ********************************************************
        d.s1 = {pulseClk, pulseDir};
        d.s2 = q.s1;
        d.s3 = q.s2;
        riseA  = q.s2[1] & ~q.s3[1];
        riseB  = q.s2[0] & ~q.s3[0];
        active = (q.regs.mode == MODE_PULSE);
        delta  = 16'sh0;
        if (active) begin
            if (q.regs.submode == SUB_CLKDIR) begin
                // only the clock line counts; direction sampled at that edge
                if (riseA) begin
                    delta = q.s2[0] ? 16'sh1 : -16'sh1;
                end
            end else begin
                // simultaneous edges on both lines cancel
                delta = (riseA ? 16'sh1 : 16'sh0) - (riseB ? 16'sh1 : 16'sh0);
            end
        end

        // ********************************************************
        // interpolation cycle timebase, 1 ms units
        // ********************************************************
        msTick  = (q.msCnt == 16'(MsCycles - 1));
        d.msCnt = msTick ? 16'h0 : q.msCnt + 16'h1;
        cycTick = 1'b0;
        if (msTick) begin
            if (q.perCnt + 16'h1 >= q.regs.period) begin
                d.perCnt = 16'h0;
                cycTick  = 1'b1;
            end else begin
                d.perCnt = q.perCnt + 16'h1;
            end
        end

        // ********************************************************
        // accumulate and scale once per cycle
        // ********************************************************
        divisor = (q.regs.den == 16'h0) ? 48'sh1 : $signed({32'h0, q.regs.den});
        prod    = $signed({{32{q.accum[15]}}, q.accum}) * $signed({32'h0, q.regs.num});
        sum     = prod + $signed({{16{q.rem[31]}}, q.rem});
        step    = sum / divisor;
        if (!active) begin
            d.accum = 16'h0;
        end else if (cycTick) begin
            // a pulse landing on the update edge opens the next cycle
            d.accum  = delta;
            d.demand = q.demand + step[31:0];
            d.rem    = 32'(sum - step * divisor);
        end else begin
            d.accum = q.accum + delta;
        end

        // ********************************************************
        // following error in closed loop
        // ********************************************************
        err    = $signed({q.demand[31], q.demand}) - $signed({q.regs.actual[31], q.regs.actual});
        errAbs = err[32] ? 33'(-err) : 33'(err);
        if (!(q.regs.closed && active)) begin
            d.feCnt = 16'h0;
            d.fe    = 1'b0;
        end else if (errAbs <= {1'b0, q.regs.feWin}) begin
            d.feCnt = 16'h0;
            d.fe    = 1'b0;
        end else if (msTick) begin
            if (q.feCnt != 16'hFFFF) begin
                d.feCnt = q.feCnt + 16'h1;
            end
            if (q.feCnt >= q.regs.feTime) begin
                d.fe = 1'b1;
            end
        end

        // ********************************************************
        // AXI4-Lite slave
        // ********************************************************
        if (s_axi_awvalid && q.axi.awRdy) begin
            d.axi.awHave = 1'b1;
            d.axi.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.axi.wRdy) begin
            d.axi.wHave = 1'b1;
            d.axi.wData = s_axi_wdata;
            d.axi.wStrb = s_axi_wstrb;
        end
        writeGo = q.axi.awHave && q.axi.wHave && !q.axi.bValid;
        wMask   = {{8{q.axi.wStrb[3]}}, {8{q.axi.wStrb[2]}}, {8{q.axi.wStrb[1]}}, {8{q.axi.wStrb[0]}}};
        wVal    = (regRead(q, q.axi.awAddr, wHit) & ~wMask) | (q.axi.wData & wMask);
        irqSet  = {!active && (riseA || riseB), d.fe && !q.fe, cycTick && active};
        d.regs.irqStat = q.regs.irqStat;
        if (writeGo) begin
            d.axi.awHave = 1'b0;
            d.axi.wHave  = 1'b0;
            d.axi.bValid = 1'b1;
            d.axi.bResp  = wHit ? RESP_OKAY : RESP_SLVERR;
            unique case (q.axi.awAddr)
                REG_CTRL: begin
                    d.regs.mode    = wVal[7:0];
                    d.regs.submode = wVal[CTRL_SUBMODE_BIT] ? SUB_CWCCW : SUB_CLKDIR;
                    d.regs.closed  = wVal[CTRL_CLOSED_BIT];
                end
                REG_NUM:     d.regs.num     = wVal[15:0];
                REG_DEN:     d.regs.den     = wVal[15:0];
                REG_PERIOD:  d.regs.period  = wVal[15:0];
                REG_IRQSTAT: d.regs.irqStat = q.regs.irqStat & ~wVal[2:0];
                REG_IRQMASK: d.regs.irqMask = wVal[2:0];
                REG_ACTUAL:  d.regs.actual  = wVal;
                REG_FEWIN:   d.regs.feWin   = wVal;
                REG_FETIME:  d.regs.feTime  = wVal[15:0];
                REG_POLES:   d.regs.poles   = wVal[15:0];
                // time index accepts only its one value; writes leave it at 1 ms
                default: ;
            endcase
        end
        // a new event beats a clear in the same cycle
        d.regs.irqStat = d.regs.irqStat | irqSet;
        if (q.axi.bValid && s_axi_bready) begin
            d.axi.bValid = 1'b0;
        end
        d.axi.awRdy = !d.axi.awHave;
        d.axi.wRdy  = !d.axi.wHave;

        rVal = regRead(q, s_axi_araddr, rHit);
        if (s_axi_arvalid && q.axi.arRdy) begin
            d.axi.rValid = 1'b1;
            d.axi.rData  = rVal;
            d.axi.rResp  = rHit ? RESP_OKAY : RESP_SLVERR;
        end else if (q.axi.rValid && s_axi_rready) begin
            d.axi.rValid = 1'b0;
        end
        d.axi.arRdy = !d.axi.rValid;

        d.irq = |(d.regs.irqStat & d.regs.irqMask);
    end

    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            q              <= '0;
            q.regs.mode    <= MODE_RESET;
            q.regs.submode <= SUB_CLKDIR;
            q.regs.num     <= NUM_RESET;
            q.regs.den     <= DEN_RESET;
            q.regs.period  <= PERIOD_RESET;
            q.regs.poles   <= POLES_RESET;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign demandPos     = q.demand;
    assign followErr     = q.fe;
    assign irq           = q.irq;
    assign s_axi_awready = q.axi.awRdy;
    assign s_axi_wready  = q.axi.wRdy;
    assign s_axi_bvalid  = q.axi.bValid;
    assign s_axi_bresp   = q.axi.bResp;
    assign s_axi_arready = q.axi.arRdy;
    assign s_axi_rvalid  = q.axi.rValid;
    assign s_axi_rdata   = q.axi.rData;
    assign s_axi_rresp   = q.axi.rResp;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSync);

    sequence clkDirUp;
        active && q.regs.submode == SUB_CLKDIR && riseA && q.s2[0] && !cycTick;
    endsequence

    sequence ccwOnly;
        active && q.regs.submode == SUB_CWCCW && riseB && !riseA && !cycTick;
    endsequence

    mode_gate_a: assert property (!active |=> q.accum == 16'h0 && $stable(q.demand))
        else $error("pulses counted outside pulse mode");
    clkdir_count_a: assert property (clkDirUp |=> q.accum == $past(q.accum) + 16'h1)
        else $error("clock edge with direction high did not count up");
    ccw_count_a: assert property (ccwOnly |=> q.accum == $past(q.accum) - 16'h1)
        else $error("counter-clockwise pulse did not count down");
    demand_hold_a: assert property (!cycTick |=> $stable(q.demand))
        else $error("demand changed between cycle updates");
    accum_clear_a: assert property (cycTick && active && delta == 16'sh0 |=> q.accum == 16'h0)
        else $error("accumulator not cleared at cycle update");
    quarter_step_a: assert property (cycTick && active && q.accum == 16'h1 && q.regs.num == NUM_RESET
        && q.regs.den == DEN_RESET && q.rem == 32'h0 |=> q.demand == $past(q.demand) + 32'h80)
        else $error("single pulse did not move demand by 128");
    open_loop_a: assert property (!q.regs.closed |=> !q.fe ##1 !q.fe || q.regs.closed)
        else $error("following error flagged in open loop");
    cycle_period_a: assert property (cycTick && q.regs.period == 16'h1 |=> !cycTick [*2])
        else $error("cycle ticks closer than one millisecond");
    irq_level_a: assert property (|(q.regs.irqStat & q.regs.irqMask) |-> q.irq)
        else $error("interrupt low with unmasked status set");

endmodule

// [verification/spi_pulse_source.sv]
// Purpose: behavioural model of the positioning controller that drives the pulse pins
// Assumes: clock pin idles low between bursts, direction pin holds its level; timing is real time, unrelated to the clock
// Notes:   200 ns on time, 320 ns period; settles after a turn
module spi_pulse_source #(
    parameter int HighNs = 200,
    parameter int LowNs  = 120,
    parameter int TurnNs = 35000,
    parameter int SkewNs = 13
) (
    output logic pulseClk,
    output logic pulseDir
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pulseClk = 1'b0;
        pulseDir = 1'b0;
    end

    // neg picks the negative sense; sub selects separate lines per sense
    task automatic send(input int n, input logic neg, input logic sub);
        logic wantDir;
        // callers start on a clock edge; the skew keeps every pin change clear of it
        #(SkewNs);
        wantDir = sub ? 1'b0 : ~neg;
        if (pulseDir !== wantDir) begin
            pulseDir = wantDir;
            #(TurnNs);
        end
        for (int i = 0; i < n; i++) begin
            if (sub && neg) pulseDir = 1'b1;
            else pulseClk = 1'b1;
            #(HighNs);
            if (sub && neg) pulseDir = 1'b0;
            else pulseClk = 1'b0;
            #(LowNs);
        end
    endtask
endmodule

// [verification/test_step_pulse_position_input.sv]
// Purpose: self-checking bench for the step pulse position input block
// Assumes: ms tick shortened to 25 clocks; cycle period set to 20 ms for most scenarios
// Notes:   bus responses are sampled on the falling edge, acted on at the next rising edge
module test_step_pulse_position_input
    import spi_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MsC = 25;
    logic        clock, nrst, pulseClk, pulseDir, followErr, irq;
    logic [7:0]  awAddr, arAddr;
    logic [31:0] wData, rData, demandPos, expDem, d;
    logic [3:0]  wStrb;
    logic [1:0]  bResp, rResp;
    logic        awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
    int          fail_count, total_checks;

    spi_step_pulse_input #(.MsCycles(MsC)) spi_step_pulse_input_inst (
        .clock(clock), .nrst(nrst), .pulseClk(pulseClk), .pulseDir(pulseDir),
        .demandPos(demandPos), .followErr(followErr), .irq(irq),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));

    spi_pulse_source spi_pulse_source_inst (.pulseClk(pulseClk), .pulseDir(pulseDir));

    always #20 clock = ~clock;

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t ns: %s got %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] expResp);
        int n;
        logic aHit, wHit, bHit;
        logic [1:0] resp;
        n = 0;
        bHit = 1'b0;
        @(posedge clock);
        awAddr <= a;
        awValid <= 1'b1;
        wData <= v;
        wStrb <= 4'hF;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!bHit && n < 100) begin
            @(negedge clock);
            aHit = awValid && awReady;
            wHit = wValid && wReady;
            bHit = bValid;
            resp = bResp;
            n++;
            @(posedge clock);
            if (aHit) awValid <= 1'b0;
            if (wHit) wValid <= 1'b0;
        end
        bReady <= 1'b0;
        check({30'h0, resp}, {30'h0, expResp}, "write response");
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] expResp);
        int n;
        logic aHit, rHit;
        logic [1:0] resp;
        n = 0;
        rHit = 1'b0;
        @(posedge clock);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        while (!rHit && n < 100) begin
            @(negedge clock);
            aHit = arValid && arReady;
            rHit = rValid;
            resp = rResp;
            v = rData;
            n++;
            @(posedge clock);
            if (aHit) arValid <= 1'b0;
        end
        rReady <= 1'b0;
        check({30'h0, resp}, {30'h0, expResp}, "read response");
    endtask

    task automatic waitIrq;
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (irq !== 1'b1 && n < 2000);
        check({31'h0, irq}, 32'h1, "interrupt raised");
        repeat (2) @(posedge clock);
    endtask

    // two cycles of 20 ms with margin, so pending pulses are applied
    task automatic settle;
        repeat (2 * 20 * MsC + 50) @(posedge clock);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic testRegs;
        rd(REG_CTRL, d, RESP_OKAY);
        check(d, 32'h0, "control reset");
        rd(REG_NUM, d, RESP_OKAY);
        check(d, 32'h80, "numerator reset");
        rd(REG_DEN, d, RESP_OKAY);
        check(d, 32'h1, "denominator reset");
        wr(REG_TIMEIDX, 32'h0, RESP_OKAY);
        rd(REG_TIMEIDX, d, RESP_OKAY);
        check(d, 32'hFFFFFFFD, "time index");
        rd(REG_POLES, d, RESP_OKAY);
        check(d, 32'h00C80032, "steps per turn");
        wr(REG_POLES, 32'h3, RESP_OKAY);
        rd(REG_POLES, d, RESP_OKAY);
        check(d, 32'h000C0003, "three pole pairs");
        rd(8'h40, d, RESP_SLVERR);
        wr(8'h40, 32'h1, RESP_SLVERR);
    endtask

    task automatic testIdle;
        spi_pulse_source_inst.send(2, 1'b0, 1'b0);
        repeat (20) @(posedge clock);
        check(demandPos, 32'h0, "pulses while inactive");
        rd(REG_IRQSTAT, d, RESP_OKAY);
        check(d & 32'h4, 32'h4, "inactive pulse event");
        wr(REG_IRQSTAT, 32'h4, RESP_OKAY);
        rd(REG_IRQSTAT, d, RESP_OKAY);
        check(d & 32'h4, 32'h0, "event cleared");
    endtask

    task automatic testClkDir;
        wr(REG_CTRL, {24'h0, MODE_PULSE}, RESP_OKAY);
        wr(REG_PERIOD, 32'h14, RESP_OKAY);
        wr(REG_IRQMASK, 32'h1, RESP_OKAY);
        waitIrq();
        wr(REG_IRQSTAT, 32'h1, RESP_OKAY);
        check({31'h0, irq}, 32'h0, "interrupt cleared");
        spi_pulse_source_inst.send(5, 1'b0, 1'b0);
        check(demandPos, expDem, "no update inside cycle");
        waitIrq();
        expDem = expDem + 32'd640;
        check(demandPos, expDem, "forward burst");
        wr(REG_IRQMASK, 32'h0, RESP_OKAY);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0, "interrupt masked");
        rd(REG_IRQSTAT, d, RESP_OKAY);
        check(d & 32'h1, 32'h1, "cycle event pending");
        spi_pulse_source_inst.send(3, 1'b1, 1'b0);
        settle();
        expDem = expDem - 32'd384;
        check(demandPos, expDem, "reverse burst");
    endtask

    task automatic testScale;
        wr(REG_NUM, 32'h3, RESP_OKAY);
        wr(REG_DEN, 32'h2, RESP_OKAY);
        spi_pulse_source_inst.send(3, 1'b0, 1'b0);
        settle();
        expDem = expDem + 32'd4;
        check(demandPos, expDem, "ratio three halves");
        spi_pulse_source_inst.send(1, 1'b0, 1'b0);
        settle();
        expDem = expDem + 32'd2;
        check(demandPos, expDem, "remainder carried");
        wr(REG_NUM, 32'h80, RESP_OKAY);
        wr(REG_DEN, 32'h1, RESP_OKAY);
        wr(REG_DEMAND, 32'h5, RESP_OKAY);
        rd(REG_DEMAND, d, RESP_OKAY);
        check(d, expDem, "demand read only");
    endtask

    task automatic testCwCcw;
        wr(REG_CTRL, {23'h0, 1'b1, MODE_PULSE}, RESP_OKAY);
        spi_pulse_source_inst.send(4, 1'b0, 1'b1);
        settle();
        expDem = expDem + 32'd512;
        check(demandPos, expDem, "clockwise line");
        spi_pulse_source_inst.send(2, 1'b1, 1'b1);
        settle();
        expDem = expDem - 32'd256;
        check(demandPos, expDem, "counter line");
    endtask

    task automatic testFollow;
        wr(REG_FEWIN, 32'hA, RESP_OKAY);
        wr(REG_FETIME, 32'h2, RESP_OKAY);
        wr(REG_ACTUAL, expDem, RESP_OKAY);
        wr(REG_IRQMASK, 32'h2, RESP_OKAY);
        wr(REG_CTRL, {22'h0, 2'b11, MODE_PULSE}, RESP_OKAY);
        settle();
        check({31'h0, followErr}, 32'h0, "inside window");
        spi_pulse_source_inst.send(1, 1'b0, 1'b1);
        expDem = expDem + 32'd128;
        waitIrq();
        check({31'h0, followErr}, 32'h1, "following error");
        rd(REG_STATUS, d, RESP_OKAY);
        check(d & 32'h2000, 32'h2000, "status bit");
        wr(REG_ACTUAL, expDem, RESP_OKAY);
        repeat (2) @(posedge clock);
        check({31'h0, followErr}, 32'h0, "error cleared");
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        awAddr = 8'h00;
        awValid = 1'b0;
        wData = 32'h0;
        wStrb = 4'h0;
        wValid = 1'b0;
        bReady = 1'b0;
        arAddr = 8'h00;
        arValid = 1'b0;
        rReady = 1'b0;
        fail_count = 0;
        total_checks = 0;
        expDem = 32'h0;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        testRegs();
        testIdle();
        testClkDir();
        testScale();
        testCwCcw();
        testFollow();
        results();
    end

    // the whole sequence needs well under a millisecond of simulated time
    initial begin
        #2000000;
        fail_count++;
        $display("mismatch at %0t ns: watchdog expired", $time);
        results();
    end
endmodule
